// ==== src/apdu_pkg.sv ====
// Constants for the automatic power-down unit
package apdu_pkg;
  // Register offsets within the internal register page
  localparam logic [7:0] APDU_CTRL0_OFFSET = 8'hB0;
  localparam logic [7:0] APDU_CTRL1_OFFSET = 8'hB1;
  localparam logic [7:0] APDU_CTRL0_RESET = 8'h00;
  localparam logic [7:0] APDU_CTRL1_RESET = 8'h00;
  // power_mode_control_0 fields
  localparam int APDU_C0_APD_OPERATE = 0;
  localparam int APDU_C0_POLARITY = 1;
  localparam int APDU_C0_AUTO_POWERDOWN_ENABLE = 2;
  localparam int APDU_C0_MEM_SAVER = 3;
  localparam int APDU_C0_FAST_OFF = 4;
  localparam int APDU_C0_ARRAY_CLK_OFF = 5;
  localparam int APDU_C0_CELL_CLK_OFF = 6;
  localparam int APDU_C0_TIMER_CLK_OFF = 7;
  // power_mode_control_1 fields
  localparam int APDU_C1_CLK_SELECT = 0;
  localparam int APDU_C1_SLEEP_ENABLE = 1;
  localparam logic [7:0] APDU_C1_USED_MASK = 8'h03;
  // Counter
  localparam int APDU_COUNT_WIDTH = 4;
  localparam logic [3:0] APDU_COUNT_OVERFLOW = 4'hF;
  // Timing
  localparam int APDU_CLK_PERIOD_NS = 50;
  localparam int APDU_ARRAY_IDLE_NS = 70;
  localparam int APDU_ARRAY_IDLE_CYCLES =
    (APDU_ARRAY_IDLE_NS + APDU_CLK_PERIOD_NS - 1) / APDU_CLK_PERIOD_NS;
  localparam int APDU_SLOW_INPUT_NS = 67;
  localparam int APDU_SLOW_INPUT_CYCLES =
    (APDU_SLOW_INPUT_NS + APDU_CLK_PERIOD_NS - 1) / APDU_CLK_PERIOD_NS;
  // Standby state, Gray coded along active -> power-down -> sleep
  typedef enum logic [1:0] {
    APDU_ACTIVE = 2'b00,
    APDU_POWERDOWN = 2'b01,
    APDU_SLEEP = 2'b11
  } apdu_mode_type;
endpackage

// ==== src/apdu_power_unit.sv ====
// Automatic power-down, sleep and power gating control
`timescale 1ns/100ps
// Notes on behaviour
// - Chip select high powers down at once
// - Deselected device blocks host signals to array
// - Static strobe: count 15 clocks, then power-down
// - Power-down also enters sleep when sleep and polarity bits set
// - Strobe activity leaves power-down or sleep immediately
// - Control1 bit 0 picks counter clock, aux after reset
// - Control0 bit 1 sets strobe idle level
// - Control0 bit 2 enables automatic power-down counting
// - Count only while strobe static at idle level
// - Sleep needs sleep, enable, polarity bits, overflow
// - Array keeps responding in sleep, slower
// - Saver off: code memory on while selected and not powered down
// - Saver on: code memory standby when unaccessed
// - Byte bus with saver powers one half only
// - Control0 bit 4 lets array power down
// - Array idles after 70 ns static inputs
// - Control0 bit 5 cuts main clock from array
// - Bits 6 and 7 cut cell and timer clocks
// - Counter clock stops once unit powers down
// - Clock buffer off when bits 5-7 and overflow
module apdu_power_unit
  import apdu_pkg::*;
#(
  parameter int COUNT_WIDTH = APDU_COUNT_WIDTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic chip_select_n,
  input wire logic addr_strobe,
  input wire logic aux_clock_pin,
  input wire logic main_clock_pin,
  input wire logic reg_select,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic bus_width_8,
  input wire logic addr_lsb,
  input wire logic code_mem_access,
  input wire logic sram_access,
  input wire logic array_inputs_changed,
  output logic powerdown_signal,
  output logic sleep_mode,
  output logic device_standby,
  output logic bus_buffer_enable,
  output logic code_mem_power,
  output logic sram_power,
  output logic mem_even_enable,
  output logic mem_odd_enable,
  output logic array_power,
  output logic array_slow,
  output logic array_clock_gate,
  output logic cell_register_clock_gate,
  output logic timer_clock_gate,
  output logic main_clock_buffer_enable,
  output logic counter_clock_run
);
  localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = {COUNT_WIDTH{1'b1}};

  logic [7:0] power_mode_control_0;
  logic [7:0] power_mode_control_1;
  logic [COUNT_WIDTH-1:0] apd_count;
  apdu_mode_type mode;
  apdu_mode_type next_mode;
  logic strobe_q;
  logic counter_clock_q;
  logic main_clock_q;
  logic counter_clock_in;
  logic counter_clock_edge;
  logic strobe_idle;
  logic count_allowed;
  logic overflow;
  logic sleep_allowed;
  logic array_activity;
  logic [1:0] array_idle_count;
  logic [1:0] slow_gap_count;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    return reg_select && (addr == offset);
  endfunction

  // Register writes, reserved bits of control1 kept at zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      power_mode_control_0 <= APDU_CTRL0_RESET;
      power_mode_control_1 <= APDU_CTRL1_RESET;
    end else if (clk_en && reg_write) begin
      if (reg_hit(reg_addr, APDU_CTRL0_OFFSET)) begin
        power_mode_control_0 <= reg_wdata;
      end
      if (reg_hit(reg_addr, APDU_CTRL1_OFFSET)) begin
        power_mode_control_1 <= reg_wdata & APDU_C1_USED_MASK;
      end
    end
  end

  // Registered read data, zero for unmapped offsets
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_read) begin
      if (reg_hit(reg_addr, APDU_CTRL0_OFFSET)) begin
        reg_rdata <= power_mode_control_0;
      end else if (reg_hit(reg_addr, APDU_CTRL1_OFFSET)) begin
        reg_rdata <= power_mode_control_1;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Counter clock source and edge detect
  assign counter_clock_in = power_mode_control_1[APDU_C1_CLK_SELECT] ?
                            main_clock_pin : aux_clock_pin;
  assign counter_clock_edge = counter_clock_in && !counter_clock_q &&
                              counter_clock_run;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strobe_q <= 1'b0;
      counter_clock_q <= 1'b0;
      main_clock_q <= 1'b0;
    end else if (clk_en) begin
      strobe_q <= addr_strobe;
      counter_clock_q <= counter_clock_in;
      main_clock_q <= main_clock_pin;
    end
  end

  // Strobe static at programmed idle level
  assign strobe_idle = (addr_strobe == power_mode_control_0[APDU_C0_POLARITY]) &&
                       (strobe_q == addr_strobe);
  assign count_allowed = power_mode_control_0[APDU_C0_AUTO_POWERDOWN_ENABLE] && strobe_idle;
  assign overflow = (apd_count == COUNT_MAX);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      apd_count <= '0;
    end else if (clk_en) begin
      if (!count_allowed) begin
        apd_count <= '0;
      end else if (counter_clock_edge && !overflow) begin
        apd_count <= apd_count + 1'b1;
      end
    end
  end

  assign sleep_allowed = power_mode_control_1[APDU_C1_SLEEP_ENABLE] &&
                         power_mode_control_0[APDU_C0_AUTO_POWERDOWN_ENABLE] &&
                         power_mode_control_0[APDU_C0_POLARITY];

  always_comb begin
    next_mode = mode;
    case (mode)
      APDU_ACTIVE: begin
        if (count_allowed && overflow) begin
          next_mode = sleep_allowed ? APDU_SLEEP : APDU_POWERDOWN;
        end
      end
      APDU_POWERDOWN, APDU_SLEEP: begin
        if (!count_allowed) begin
          next_mode = APDU_ACTIVE;
        end else begin
          next_mode = sleep_allowed ? APDU_SLEEP : APDU_POWERDOWN;
        end
      end
      default: next_mode = APDU_ACTIVE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode <= APDU_ACTIVE;
    end else if (clk_en) begin
      mode <= next_mode;
    end
  end

  assign powerdown_signal = (mode != APDU_ACTIVE);
  assign sleep_mode = (mode == APDU_SLEEP);
  assign counter_clock_run = (mode == APDU_ACTIVE);
  assign device_standby = chip_select_n || powerdown_signal;
  assign bus_buffer_enable = !chip_select_n;

  // Memory current saving
  always_comb begin
    if (chip_select_n || powerdown_signal) begin
      code_mem_power = 1'b0;
      sram_power = 1'b0;
    end else if (power_mode_control_0[APDU_C0_MEM_SAVER]) begin
      code_mem_power = code_mem_access;
      sram_power = sram_access;
    end else begin
      code_mem_power = 1'b1;
      sram_power = sram_access;
    end
    if (power_mode_control_0[APDU_C0_MEM_SAVER] && bus_width_8) begin
      mem_even_enable = !addr_lsb;
      mem_odd_enable = addr_lsb;
    end else begin
      mem_even_enable = 1'b1;
      mem_odd_enable = 1'b1;
    end
  end

  // Logic array zero-power tracking
  assign array_activity = array_inputs_changed ||
    (!power_mode_control_0[APDU_C0_ARRAY_CLK_OFF] &&
     (main_clock_pin != main_clock_q));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      array_idle_count <= '0;
    end else if (clk_en) begin
      if (array_activity) begin
        array_idle_count <= '0;
      end else if (array_idle_count != 2'(APDU_ARRAY_IDLE_CYCLES)) begin
        array_idle_count <= array_idle_count + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      slow_gap_count <= '0;
    end else if (clk_en) begin
      if (array_inputs_changed) begin
        slow_gap_count <= '0;
      end else if (slow_gap_count != 2'(APDU_SLOW_INPUT_CYCLES)) begin
        slow_gap_count <= slow_gap_count + 1'b1;
      end
    end
  end

  assign array_power = !power_mode_control_0[APDU_C0_FAST_OFF] ||
                       (array_idle_count != 2'(APDU_ARRAY_IDLE_CYCLES));
  assign array_slow = sleep_mode ||
    (power_mode_control_0[APDU_C0_FAST_OFF] &&
     slow_gap_count == 2'(APDU_SLOW_INPUT_CYCLES));

  assign array_clock_gate = !power_mode_control_0[APDU_C0_ARRAY_CLK_OFF];
  assign cell_register_clock_gate = !power_mode_control_0[APDU_C0_CELL_CLK_OFF];
  assign timer_clock_gate = !power_mode_control_0[APDU_C0_TIMER_CLK_OFF];
  assign main_clock_buffer_enable = !(&power_mode_control_0[7:5] && overflow);

  // Checks
  property p_no_count_when_disabled;
    @(posedge core_clk) disable iff (!rst_n)
      (clk_en && !power_mode_control_0[APDU_C0_AUTO_POWERDOWN_ENABLE]) |=> (apd_count == '0);
  endproperty
  count_disable_a: assert property (p_no_count_when_disabled)
    else $error("counter moved while disabled");

  pd_entry_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && mode == APDU_ACTIVE && count_allowed && overflow) |=> powerdown_signal)
    else $error("overflow did not power down");

  pd_exit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && !count_allowed) |=> !powerdown_signal && apd_count == '0)
    else $error("strobe activity did not wake");

  sleep_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(sleep_mode) |-> $past(sleep_allowed) && $past(overflow))
    else $error("sleep without its enables");

  pd_needs_count_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(powerdown_signal) |-> $past(apd_count) == COUNT_MAX)
    else $error("power-down before fifteen clocks");

  counter_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && powerdown_signal && count_allowed) |=> $stable(apd_count))
    else $error("counter ran while powered down");

  cs_standby_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    chip_select_n |-> device_standby && !bus_buffer_enable && !code_mem_power)
    else $error("deselect did not power down");

  mem_saver_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!chip_select_n && !powerdown_signal && !power_mode_control_0[APDU_C0_MEM_SAVER])
      |-> code_mem_power)
    else $error("code memory off with saver off");

  array_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (clk_en && power_mode_control_0[APDU_C0_FAST_OFF] && array_activity) ##1
      (clk_en && power_mode_control_0[APDU_C0_FAST_OFF] && !array_activity) [*2]
      |=> !array_power)
    else $error("array stayed powered while idle");

  clk_buffer_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    main_clock_buffer_enable != (&power_mode_control_0[7:5] && apd_count == COUNT_MAX))
    else $error("clock buffer gate wrong");

  cover_pd_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(powerdown_signal));
  cover_sleep_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(sleep_mode));
  cover_wake_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    $fell(powerdown_signal));
endmodule

// ==== sim/apdu_host_model.sv ====
// Host bus model driving the strobe and both counter clock pins
`timescale 1ns/100ps
module apdu_host_model (
  input wire logic core_clk,
  input wire logic strobe_run,
  input wire logic idle_level,
  input wire logic aux_run,
  output logic addr_strobe,
  output logic main_clock_pin,
  output logic aux_clock_pin
);
  logic nxt_strobe;
  logic nxt_aux;
  logic strobe_level = 1'b0;
  logic main_level = 1'b0;
  logic aux_level = 1'b0;
  assign addr_strobe = strobe_level;
  assign main_clock_pin = main_level;
  assign aux_clock_pin = aux_level;
  // Inputs sampled at the edge, pins change just after it
  always @(posedge core_clk) begin
    nxt_strobe = strobe_run ? !strobe_level : idle_level;
    nxt_aux = aux_run ? !aux_level : aux_level;
    #1;
    strobe_level = nxt_strobe;
    main_level = !main_level;
    aux_level = nxt_aux;
  end
endmodule

// ==== sim/auto_power_down_unit_tb_top.sv ====
// Self-checking bench for the automatic power-down unit
`timescale 1ns/100ps
module auto_power_down_unit_tb_top;
  import apdu_pkg::*;
  localparam logic [7:0] R0 = APDU_CTRL0_OFFSET;
  localparam logic [7:0] R1 = APDU_CTRL1_OFFSET;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic array_slow;
  logic chip_select_n = 1'b0;
  logic reg_select = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic bus_width_8 = 1'b0;
  logic addr_lsb = 1'b0;
  logic code_mem_access = 1'b0;
  logic sram_access = 1'b0;
  logic array_inputs_changed = 1'b1;
  logic strobe_run = 1'b1;
  logic idle_level = 1'b0;
  logic aux_run = 1'b0;
  logic addr_strobe, main_clock_pin, aux_clock_pin;
  logic [7:0] reg_rdata;
  logic powerdown_signal, sleep_mode, device_standby, bus_buffer_enable;
  logic code_mem_power, sram_power, mem_even_enable, mem_odd_enable;
  logic array_power, array_clock_gate, cell_register_clock_gate, timer_clock_gate;
  logic main_clock_buffer_enable, counter_clock_run;
  int bad_count;
  int cmp_count;

  always #25 core_clk = !core_clk;

  apdu_host_model u_host (.core_clk, .strobe_run, .idle_level, .aux_run,
    .addr_strobe, .main_clock_pin, .aux_clock_pin);

  apdu_power_unit u_dut (.core_clk, .rst_n, .clk_en, .chip_select_n,
    .addr_strobe, .aux_clock_pin, .main_clock_pin, .reg_select, .reg_addr,
    .reg_write, .reg_read, .reg_wdata, .reg_rdata, .bus_width_8, .addr_lsb,
    .code_mem_access, .sram_access, .array_inputs_changed, .powerdown_signal,
    .sleep_mode, .device_standby, .bus_buffer_enable, .code_mem_power,
    .sram_power, .mem_even_enable, .mem_odd_enable, .array_power,
    .array_slow, .array_clock_gate, .cell_register_clock_gate,
    .timer_clock_gate, .main_clock_buffer_enable, .counter_clock_run);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    reg_select = 1'b1;
    reg_addr = a;
    reg_write = wr;
    reg_read = !wr;
    reg_wdata = d;
    cyc(1);
    reg_select = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(reg_rdata, e);
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Program, hold strobe idle, expect overflow, then wake by pulsing
  task automatic auto_powerdown(input logic [7:0] c0, input logic [7:0] c1, input logic sl);
    int n;
    acc(1'b1, R0, c0);
    acc(1'b1, R1, c1);
    idle_level = c0[1];
    strobe_run = 1'b0;
    cyc(24);
    chk(powerdown_signal, 1'b0);
    n = 0;
    while (powerdown_signal !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk(powerdown_signal, 1'b1);
    chk(device_standby, 1'b1);
    chk(sleep_mode, sl);
    chk(counter_clock_run, 1'b0);
    chk(array_slow, sl);
    chk(code_mem_power, 1'b0);
    chk(main_clock_buffer_enable, c0[7:5] != 3'b111);
    strobe_run = 1'b1;
    cyc(3);
    chk(powerdown_signal, 1'b0);
    chk(sleep_mode, 1'b0);
  endtask

  // Strobe held static long enough, but no power-down expected
  task automatic quiet(input logic [7:0] c0, input logic [7:0] c1, input logic lvl);
    acc(1'b1, R0, c0);
    acc(1'b1, R1, c1);
    idle_level = lvl;
    strobe_run = 1'b0;
    cyc(60);
    chk(powerdown_signal, 1'b0);
    strobe_run = 1'b1;
    cyc(2);
  endtask

  initial begin
    bad_count = 0;
    cmp_count = 0;
    cyc(10);
    rst_n = 1'b1;
    chk(counter_clock_run, 1'b1);
    chk({array_clock_gate, cell_register_clock_gate, timer_clock_gate}, 3'b111);
    chk(array_power, 1'b1);
    rd(R0, 8'h00);
    rd(R1, 8'h00);
    rd(8'hC0, 8'h00);
    acc(1'b1, R1, 8'hFF);
    rd(R1, 8'h03);
    acc(1'b1, R0, 8'hE0);
    chk({array_clock_gate, cell_register_clock_gate, timer_clock_gate}, 3'b000);
    chip_select_n = 1'b1;
    cyc(1);
    chk(device_standby, 1'b1);
    chk(bus_buffer_enable, 1'b0);
    chk(code_mem_power, 1'b0);
    chip_select_n = 1'b0;
    acc(1'b1, R0, 8'h80);
    chk(code_mem_power, 1'b1);
    chk(bus_buffer_enable, 1'b1);
    acc(1'b1, R0, 8'h88);
    sram_access = 1'b1;
    cyc(1);
    chk(code_mem_power, 1'b0);
    chk(sram_power, 1'b1);
    sram_access = 1'b0;
    code_mem_access = 1'b1;
    bus_width_8 = 1'b1;
    addr_lsb = 1'b1;
    cyc(1);
    chk({mem_even_enable, mem_odd_enable}, 2'b01);
    acc(1'b1, R0, 8'h20);
    array_inputs_changed = 1'b0;
    cyc(6);
    chk(array_power, 1'b1);
    acc(1'b1, R0, 8'h30);
    cyc(6);
    chk(array_power, 1'b0);
    array_inputs_changed = 1'b1;
    cyc(1);
    chk(array_power, 1'b1);
    array_inputs_changed = 1'b0;
    cyc(3);
    chk(array_power, 1'b0);
    chk(array_slow, 1'b1);
    array_inputs_changed = 1'b1;
    auto_powerdown(8'h87, 8'h01, 1'b0);
    auto_powerdown(8'h87, 8'h03, 1'b1);
    auto_powerdown(8'h85, 8'h03, 1'b0);
    auto_powerdown(8'hE7, 8'h01, 1'b0);
    quiet(8'h83, 8'h01, 1'b1);
    quiet(8'h87, 8'h01, 1'b0);
    quiet(8'h87, 8'h00, 1'b1);
    aux_run = 1'b1;
    auto_powerdown(8'h87, 8'h00, 1'b0);
    // Frozen write ignored
    clk_en = 1'b0;
    acc(1'b1, R1, 8'h03);
    clk_en = 1'b1;
    rd(R1, 8'h00);
    // Second reset in mid-run
    acc(1'b1, R1, 8'h03);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    rd(R1, 8'h00);
    rd(R0, 8'h00);
    close_out();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    cyc(3000);
    bad_count++;
    close_out();
  end
endmodule
